// File: logic/flash_rom_protection_security.sv
// Flash ROM write/erase protection and security unit, register file and command gate.
// Assumes por is asserted with rst at power-up; all inputs come from ref_clk logic.
`timescale 1ns/100ps
module flash_rom_protection_security
  import flash_prot_pkg::*;
#(
  parameter int NUM_BLOCKS = MAX_BLOCKS,
  parameter int AUTO_OP_CYC = AUTO_OP_CYC_DEF,
  parameter int RST_MIN_CYC = RST_MIN_CYC_DEF,
  parameter int READ_WAIT_CYC = READ_WAIT_CYC_DEF
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_wr_full,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash command port
  input wire logic cmd_valid,
  input wire flash_cmd_t cmd_in,
  output logic cmd_refused,
  // Flash array
  input wire logic [MAX_BLOCKS-1:0] prot_nv,
  input wire logic flash_fail,
  output logic flash_start,
  output flash_cmd_t flash_cmd,
  // Processor read path
  input wire logic cpu_rd_req,
  output logic cpu_rd_grant,
  // Debug gating and interrupt
  output logic sec_active,
  output logic dbg_enable,
  output logic trace_enable,
  output logic irq
);

  localparam logic [MAX_BLOCKS-1:0] IMPL_MASK = MAX_BLOCKS'((1 << NUM_BLOCKS) - 1);
  localparam int RST_W = $clog2(RST_MIN_CYC + 1);
  localparam int WAIT_W = $clog2(READ_WAIT_CYC + 1);
  localparam int KEY_W = $clog2(KEY_WINDOW_CLK + 1);

  // True when the block exists and its protection bit is set
  function automatic logic is_protected(input logic [MAX_BLOCKS-1:0] prot, input logic [2:0] blk);
    logic res;
    res = 1'b0;
    if (int'(blk) < NUM_BLOCKS) begin
      res = prot[blk];
    end
    return res;
  endfunction

  logic [MAX_BLOCKS-1:0] prot_r;
  logic [MAX_BLOCKS-1:0] pend_set_r;
  logic [MAX_BLOCKS-1:0] pend_clr_r;
  logic security_on_r;
  logic [KEY_W-1:0] key_cnt_r;
  logic lock_r;
  logic rst_q_r;
  logic [RST_W-1:0] rst_cnt_r;
  logic [WAIT_W-1:0] wait_cnt_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic auto_op_done;
  logic op_done;
  logic op_fail;
  logic legal;
  logic accept;
  logic recover;
  logic read_ready;
  logic sec_wr;
  logic [MAX_BLOCKS-1:0] prot_vis;

  // ************************************************************
  // Automatic operation sequencer
  // ************************************************************
  prot_auto_op #(
    .OP_CYC(AUTO_OP_CYC)
  ) u_auto_op (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(accept),
    .fail_in(flash_fail),
    .ready(auto_op_done),
    .done_pulse(op_done),
    .fail_pulse(op_fail)
  );

  // ************************************************************
  // Security state
  // ************************************************************
  assign prot_vis = prot_r & IMPL_MASK;
  assign sec_active = security_on_r && (&(prot_r | ~IMPL_MASK));
  assign sec_wr = reg_wr && (reg_addr == SEC_OFS);

  // Key window: a data write counts only while the counter runs
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      key_cnt_r <= '0;
    end else if (sec_wr && reg_wr_full && reg_wdata == UNLOCK_KEY) begin
      key_cnt_r <= KEY_W'(KEY_WINDOW_CLK);
    end else if (sec_wr && reg_wr_full && key_cnt_r != '0) begin
      key_cnt_r <= '0;
    end else if (key_cnt_r != '0) begin
      key_cnt_r <= key_cnt_r - KEY_W'(1);
    end
  end

  // Reset only by power-on reset; rst leaves it unchanged
  always_ff @(posedge ref_clk) begin
    if (por) begin
      security_on_r <= SEC_RST;
    end else if (sec_wr && reg_wr_full && reg_wdata != UNLOCK_KEY && key_cnt_r != '0) begin
      security_on_r <= reg_wdata[SEC_BIT_POS];
    end
  end

  // Debug and trace shut off while secure
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      dbg_enable <= 1'b0;
      trace_enable <= 1'b0;
    end else begin
      dbg_enable <= !sec_active;
      trace_enable <= !sec_active;
    end
  end

  // Processor reads ignore security
  assign cpu_rd_grant = cpu_rd_req && read_ready;

  // ************************************************************
  // Command gate
  // ************************************************************
  always_comb begin
    legal = 1'b0;
    if (sec_active) begin
      legal = (cmd_in.op == OP_ERASE_PROT);
    end else begin
      case (cmd_in.op)
        OP_PROG_DATA, OP_ERASE_DATA: begin
          legal = (int'(cmd_in.block) < NUM_BLOCKS) && !is_protected(prot_r, cmd_in.block);
        end
        OP_PROG_PROT: begin
          legal = (int'(cmd_in.block) < NUM_BLOCKS);
        end
        default: begin
          legal = 1'b1;
        end
      endcase
    end
  end

  assign accept = cmd_valid && !rst && !lock_r && auto_op_done && legal;
  assign cmd_refused = cmd_valid && !accept;

  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      flash_start <= 1'b0;
      flash_cmd <= '0;
    end else begin
      flash_start <= accept;
      if (accept) begin
        flash_cmd <= cmd_in;
      end
    end
  end

  // Protection change held until the operation completes
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      pend_set_r <= '0;
      pend_clr_r <= '0;
    end else if (accept) begin
      pend_set_r <= '0;
      pend_clr_r <= '0;
      if (cmd_in.op == OP_PROG_PROT) begin
        pend_set_r <= MAX_BLOCKS'(1) << cmd_in.block;
      end else if (cmd_in.op == OP_ERASE_PROT) begin
        if (sec_active) begin
          pend_clr_r <= IMPL_MASK;
        end else begin
          pend_clr_r <= (cmd_in.group ? GROUP1_MASK : GROUP0_MASK) & IMPL_MASK;
        end
      end
    end
  end

  // Nonvolatile protection copy
  always_ff @(posedge ref_clk) begin
    if (por) begin
      prot_r <= prot_nv & IMPL_MASK;
    end else if (op_done) begin
      prot_r <= (prot_r | pend_set_r) & ~pend_clr_r;
    end
  end

  // ************************************************************
  // Command lockout and recovery
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (por) begin
      rst_q_r <= 1'b0;
      rst_cnt_r <= '0;
    end else begin
      rst_q_r <= rst;
      if (!rst) begin
        rst_cnt_r <= '0;
      end else if (rst_cnt_r != RST_W'(RST_MIN_CYC)) begin
        rst_cnt_r <= rst_cnt_r + RST_W'(1);
      end
    end
  end

  assign recover = rst_q_r && !rst && (rst_cnt_r == RST_W'(RST_MIN_CYC));

  always_ff @(posedge ref_clk) begin
    if (por) begin
      lock_r <= 1'b0;
    end else if (recover) begin
      lock_r <= 1'b0;
    end else if (cmd_valid && !rst && !auto_op_done) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (por) begin
      wait_cnt_r <= '0;
    end else if (recover && lock_r) begin
      wait_cnt_r <= WAIT_W'(READ_WAIT_CYC);
    end else if (wait_cnt_r != '0) begin
      wait_cnt_r <= wait_cnt_r - WAIT_W'(1);
    end
  end

  assign read_ready = (wait_cnt_r == '0);

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE] = op_done;
    irq_set[IRQ_FAIL] = op_fail;
    irq_set[IRQ_REFUSED] = cmd_refused;
    irq_set[IRQ_LOCK] = cmd_valid && !rst && !auto_op_done && !lock_r;
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && reg_addr == IRQ_STAT_OFS) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata[IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      irq_stat_r <= '0;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr && reg_addr == IRQ_MASK_OFS) begin
        irq_mask_r <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ************************************************************
  // Register read
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == SEC_OFS) begin
      reg_rdata <= 32'(security_on_r) << SEC_BIT_POS;
    end else if (reg_addr == FLCS_OFS) begin
      reg_rdata <= (32'(prot_vis) << PROT_LSB) | (32'(auto_op_done) << READY_POS);
    end else if (reg_addr == IRQ_STAT_OFS) begin
      reg_rdata <= 32'(irq_stat_r);
    end else if (reg_addr == IRQ_MASK_OFS) begin
      reg_rdata <= 32'(irq_mask_r);
    end else begin
      reg_rdata <= '0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_prot_refuse;
    @(posedge ref_clk) disable iff (rst || por)
      (cmd_valid && cmd_in.op inside {OP_PROG_DATA, OP_ERASE_DATA} && is_protected(prot_r, cmd_in.block))
      |=> !flash_start;
  endproperty
  a_prot_refuse: assert property (p_prot_refuse) else $error("protected block accepted");

  property p_status_read;
    @(posedge ref_clk) disable iff (rst || por)
      (reg_rd && reg_addr == FLCS_OFS) |=> (reg_rdata[21:16] == $past(prot_vis)) && (reg_rdata[15:1] == 15'h0);
  endproperty
  a_status_read: assert property (p_status_read) else $error("protection status mismatch");

  property p_short_variant;
    @(posedge ref_clk) disable iff (rst || por)
      (reg_rd && reg_addr == FLCS_OFS && NUM_BLOCKS == 4) |=> (reg_rdata[21:20] == 2'h0);
  endproperty
  a_short_variant: assert property (p_short_variant) else $error("unused status bits nonzero");

  property p_sec_cond;
    @(posedge ref_clk) disable iff (rst || por)
      sec_active |-> (security_on_r && ((prot_r & IMPL_MASK) == IMPL_MASK));
  endproperty
  a_sec_cond: assert property (p_sec_cond) else $error("security active without conditions");

  property p_debug_block;
    @(posedge ref_clk) disable iff (rst || por)
      sec_active [*2] |-> !dbg_enable && !trace_enable;
  endproperty
  a_debug_block: assert property (p_debug_block) else $error("debug open while secure");

  property p_cmd_ignore;
    @(posedge ref_clk) disable iff (rst || por)
      (sec_active && cmd_valid && cmd_in.op != OP_ERASE_PROT) |=> !flash_start;
  endproperty
  a_cmd_ignore: assert property (p_cmd_ignore) else $error("command taken while secure");

  property p_sec_erase_all;
    @(posedge ref_clk) disable iff (rst || por)
      (accept && sec_active) |=> (pend_clr_r == IMPL_MASK);
  endproperty
  a_sec_erase_all: assert property (p_sec_erase_all) else $error("secure erase not full");

  property p_busy_flag;
    @(posedge ref_clk) disable iff (rst || por)
      accept |=> !auto_op_done [*2];
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("ready during operation");

  property p_fail_hold;
    @(posedge ref_clk) disable iff (rst || por)
      op_fail |-> !auto_op_done [*8];
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("ready after failure");

  property p_key_guard;
    @(posedge ref_clk) disable iff (rst || por)
      (key_cnt_r == '0) |=> $stable(security_on_r);
  endproperty
  a_key_guard: assert property (p_key_guard) else $error("security bit changed without key");

endmodule // flash_rom_protection_security

// File: logic/prot_auto_op.sv
// Automatic flash operation sequencer with the ready/busy flag.
// Assumes start and fail_in come from logic on ref_clk.
`timescale 1ns/100ps
module prot_auto_op
  import flash_prot_pkg::*;
#(
  parameter int OP_CYC = AUTO_OP_CYC_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic fail_in,
  // Status
  output logic ready,
  output logic done_pulse,
  output logic fail_pulse
);

  localparam int CNT_W = $clog2(OP_CYC + 1);

  auto_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic last;

  assign last = (cnt_r == CNT_W'(OP_CYC - 1));

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= S_READY;
    end else begin
      case (state_r)
        S_READY: begin
          if (start) begin
            state_r <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (fail_in) begin
            state_r <= S_FAILED;
          end else if (last) begin
            state_r <= S_READY;
          end
        end
        default: begin
          state_r <= S_FAILED;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state_r != S_BUSY) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_pulse <= 1'b0;
      fail_pulse <= 1'b0;
    end else begin
      done_pulse <= (state_r == S_BUSY) && last && !fail_in;
      fail_pulse <= (state_r == S_BUSY) && fail_in;
    end
  end

  // Ready once the finished result has been applied
  assign ready = (state_r == S_READY) && !done_pulse;

endmodule // prot_auto_op

// File: pkg/flash_prot_pkg.sv
// Shared constants and types for the flash ROM protection and security unit.
// Assumes a 125 MHz system clock and a plain register port with 8-bit byte addresses.
package flash_prot_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] SEC_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] FLCS_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h44;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int SEC_BIT_POS = 0;
  localparam int READY_POS = 0;
  localparam int PROT_LSB = 16;
  localparam int MAX_BLOCKS = 6;
  localparam logic SEC_RST = 1'b1;
  localparam logic READY_RST = 1'b1;
  localparam logic [31:0] UNLOCK_KEY = 32'ha74a9d23;
  localparam logic [MAX_BLOCKS-1:0] GROUP0_MASK = 6'h0f;
  localparam logic [MAX_BLOCKS-1:0] GROUP1_MASK = 6'h30;

  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_LOCK = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int KEY_WINDOW_CLK = 16;
  localparam int RST_MIN_US = 500;
  localparam int READ_WAIT_US = 2000;
  localparam int RST_MIN_CYC_DEF = RST_MIN_US * CLK_MHZ;
  localparam int READ_WAIT_CYC_DEF = READ_WAIT_US * CLK_MHZ;
  localparam int AUTO_OP_CYC_DEF = 64;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {OP_PROG_DATA, OP_ERASE_DATA, OP_PROG_PROT, OP_ERASE_PROT} flash_op_t;

  typedef struct packed {
    flash_op_t op;
    logic [2:0] block;
    logic group;
  } flash_cmd_t;

  typedef enum logic [1:0] {S_READY, S_BUSY, S_FAILED} auto_state_t;

endpackage

// File: verif/tb_top.sv
// Self-checking testbench for the flash ROM protection and security unit.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/100ps
module tb_top;
  import flash_prot_pkg::*;

  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic ref_clk, rst, por;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_wr_full, reg_rd;
  logic cmd_valid, cmd_refused, flash_fail, flash_start;
  flash_cmd_t cmd_in, flash_cmd;
  logic [MAX_BLOCKS-1:0] prot_nv;
  logic cpu_rd_req, cpu_rd_grant, sec_active, dbg_enable, trace_enable, irq;
  int fail_count, samples_checked, cycle_count;
  logic [31:0] rdata4;

  flash_rom_protection_security #(.NUM_BLOCKS(6), .AUTO_OP_CYC(4), .RST_MIN_CYC(8), .READ_WAIT_CYC(8)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_wr_full(reg_wr_full), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
    .cmd_refused(cmd_refused), .prot_nv(prot_nv), .flash_fail(flash_fail), .flash_start(flash_start),
    .flash_cmd(flash_cmd), .cpu_rd_req(cpu_rd_req), .cpu_rd_grant(cpu_rd_grant), .sec_active(sec_active),
    .dbg_enable(dbg_enable), .trace_enable(trace_enable), .irq(irq)
  );

  // Four-block variant shares the stimulus except it gets ~prot_nv; only its read data is judged
  flash_rom_protection_security #(.NUM_BLOCKS(4), .AUTO_OP_CYC(4), .RST_MIN_CYC(8), .READ_WAIT_CYC(8)) dut4_u (
    .ref_clk(ref_clk), .rst(rst), .por(por), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_wr_full(reg_wr_full), .reg_rd(reg_rd), .reg_rdata(rdata4), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
    .cmd_refused(), .prot_nv(~prot_nv), .flash_fail(flash_fail), .flash_start(), .flash_cmd(),
    .cpu_rd_req(cpu_rd_req), .cpu_rd_grant(), .sec_active(), .dbg_enable(), .trace_enable(), .irq()
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic full);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_full <= full;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  // Security bit write: key, idle gap, then data
  task automatic set_sec(input logic b, input int gap);
    wr(SEC_OFS, UNLOCK_KEY, 1'b1);
    repeat (gap) @(posedge ref_clk);
    wr(SEC_OFS, {31'h0, b}, 1'b1);
  endtask

  // Issue one command; when taken, check the launch and wait for ready
  task automatic cmd(input flash_op_t op, input logic [2:0] blk, input logic grp, input logic refuse);
    flash_cmd_t c;
    logic [31:0] d;
    c = '{op: op, block: blk, group: grp};
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_in <= c;
    @(negedge ref_clk);
    check("cmd_refused", {31'h0, cmd_refused}, {31'h0, refuse});
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    if (!refuse) begin
      @(negedge ref_clk);
      check("flash_start", {31'h0, flash_start}, 32'h1);
      check("flash_cmd", {26'h0, flash_cmd}, {26'h0, c});
      rd(FLCS_OFS, d);
      check("busy flag", {31'h0, d[READY_POS]}, 32'h0);
      for (int i = 0; i < 20 && d[READY_POS] !== 1'b1 && !flash_fail; i++) begin
        rd(FLCS_OFS, d);
      end
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values;
    logic [31:0] d;
    rd_check("security reg", SEC_OFS, 32'h1);
    rd(FLCS_OFS, d);
    check("status reg", d, 32'h0005_0001);
    check("four-block status", rdata4, 32'h000a_0001);
    rd_check("irq status", IRQ_STAT_OFS, 32'h0);
    rd_check("irq mask", IRQ_MASK_OFS, 32'h0);
    rd_check("unmapped", 8'h04, 32'h0);
    wr(FLCS_OFS, 32'hffff_fffe, 1'b1);
    rd_check("status read only", FLCS_OFS, 32'h0005_0001);
    check("sec_active idle", {31'h0, sec_active}, 32'h0);
    check("dbg idle", {31'h0, dbg_enable}, 32'h1);
    check("trace idle", {31'h0, trace_enable}, 32'h1);
  endtask

  task automatic t_protect_irq;
    wr(IRQ_MASK_OFS, 32'hf, 1'b1);
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b1);
    @(negedge ref_clk);
    check("irq refused", {31'h0, irq}, 32'h1);
    rd_check("irq status refused", IRQ_STAT_OFS, 32'h4);
    wr(IRQ_STAT_OFS, 32'h4, 1'b1);
    @(negedge ref_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    cmd(OP_PROG_DATA, 3'h1, 1'b0, 1'b0);
    cmd(OP_PROG_PROT, 3'h1, 1'b0, 1'b0);
    rd_check("status after prog", FLCS_OFS, 32'h0007_0001);
    wr(IRQ_MASK_OFS, 32'h0, 1'b1);
    rd_check("irq status done", IRQ_STAT_OFS, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(IRQ_STAT_OFS, 32'hf, 1'b1);
  endtask

  task automatic t_security_key;
    set_sec(1'b0, 14);
    rd_check("key last clock", SEC_OFS, 32'h0);
    set_sec(1'b1, 15);
    rd_check("key expired", SEC_OFS, 32'h0);
    wr(SEC_OFS, UNLOCK_KEY, 1'b1);
    wr(SEC_OFS, 32'h1, 1'b0);
    rd_check("narrow write", SEC_OFS, 32'h0);
    repeat (KEY_WINDOW_CLK) @(posedge ref_clk);
    wr(SEC_OFS, 32'h1, 1'b1);
    rd_check("no key", SEC_OFS, 32'h0);
  endtask

  task automatic t_groups_secure;
    cmd(OP_PROG_PROT, 3'h3, 1'b0, 1'b0);
    cmd(OP_PROG_PROT, 3'h4, 1'b0, 1'b0);
    cmd(OP_PROG_PROT, 3'h5, 1'b0, 1'b0);
    check("sec off all prot", {31'h0, sec_active}, 32'h0);
    rd_check("sec cleared before erase", SEC_OFS, 32'h0);
    cmd(OP_ERASE_PROT, 3'h0, 1'b0, 1'b0);
    rd_check("group erase", FLCS_OFS, 32'h0030_0001);
    for (int b = 0; b < 4; b++) begin
      cmd(OP_PROG_PROT, b[2:0], 1'b0, 1'b0);
    end
    set_sec(1'b1, 0);
    repeat (3) @(negedge ref_clk);
    check("sec_active", {31'h0, sec_active}, 32'h1);
    check("dbg blocked", {31'h0, dbg_enable}, 32'h0);
    check("trace blocked", {31'h0, trace_enable}, 32'h0);
    check("cpu read", {31'h0, cpu_rd_grant}, 32'h1);
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b1);
    cmd(OP_ERASE_DATA, 3'h1, 1'b0, 1'b1);
    cmd(OP_PROG_PROT, 3'h2, 1'b0, 1'b1);
    cmd(OP_ERASE_PROT, 3'h0, 1'b1, 1'b0);
    rd_check("secure erase", FLCS_OFS, 32'h0000_0001);
    repeat (2) @(negedge ref_clk);
    check("sec released", {31'h0, sec_active}, 32'h0);
    check("dbg back", {31'h0, dbg_enable}, 32'h1);
  endtask

  task automatic t_fail_lock;
    logic [31:0] d;
    wr(IRQ_STAT_OFS, 32'hf, 1'b1);
    flash_fail <= 1'b1;
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    flash_fail <= 1'b0;
    rd_check("failed stays busy", FLCS_OFS, 32'h0);
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b1);
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b1);
    rd(IRQ_STAT_OFS, d);
    check("fail lock irq", {29'h0, d[3:1]}, 32'h7);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check("read held off", {31'h0, cpu_rd_grant}, 32'h0);
    repeat (7) @(negedge ref_clk);
    check("read held last", {31'h0, cpu_rd_grant}, 32'h0);
    @(negedge ref_clk);
    check("read resumed", {31'h0, cpu_rd_grant}, 32'h1);
    rd_check("sec kept", SEC_OFS, 32'h1);
    rd_check("ready after rst", FLCS_OFS, 32'h1);
    cmd(OP_PROG_DATA, 3'h0, 1'b0, 1'b0);
  endtask

  // ************************************************************
  // Main sequence and timeout
  // ************************************************************
  always @(posedge ref_clk) begin
    cycle_count++;
    if (cycle_count >= 6000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    cycle_count = 0;
    rst = 1'b1;
    por = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_wr_full = 1'b0;
    reg_rd = 1'b0;
    cmd_valid = 1'b0;
    cmd_in = '0;
    prot_nv = 6'h05;
    flash_fail = 1'b0;
    cpu_rd_req = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_reset_values();
    t_protect_irq();
    t_security_key();
    t_groups_secure();
    t_fail_lock();
    finish_test();
  end
endmodule // tb_top
